// >>> src/iocst_pkg.sv
/*
 * Constants for the search/translate transfer engine of an I/O channel controller.
 * Assumes bit 0 of each documented byte is its most significant bit, as printed.
 */
package iocst_pkg;
    // Controller order codes.
    localparam logic [2:0] COC_NONE = 3'h0;
    localparam logic [2:0] COC_XLATE = 3'h1;
    localparam logic [2:0] COC_XLATE_INT = 3'h5;
    localparam logic [2:0] COC_SEARCH = 3'h6;
    localparam logic [2:0] COC_BOTH = 3'h7;
    // Interrupt condition byte vector bit positions; printed bit n sits at vector bit 7-n.
    localparam int ICB_SEARCH_HIT = 7;
    localparam int ICB_COUNT_ZERO = 6;
    localparam int ICB_NOT_READY = 5;
    localparam int ICB_EOR = 4;
    localparam int ICB_ATTN = 3;
    localparam int ICB_ERROR = 2;
    localparam int ICB_CARRIER = 1;
    // Address bit that selects the upper 64K region.
    localparam int ADDR_UPPER_BIT = 15;
    // Move unit order byte fields (printed bit n sits at vector bit 7-n).
    localparam int MV_DIR_HI = 4;
    localparam int MV_DIR_LO = 3;
    localparam int MV_STEP = 2;
    localparam int MV_DIAG = 1;
    localparam int MV_NOINT = 0;
    localparam int EX_STB_UPPER = 6;
    localparam int EX_CRC = 4;
    localparam int EX_MASKTEST = 3;
    localparam logic [2:0] OP_MOVE = 3'h0;
    localparam logic [2:0] OP_OR = 3'h1;
    localparam logic [2:0] OP_AND = 3'h3;
    localparam logic [2:0] OP_XOR = 3'h5;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [16:0] ADDR_STEP = 17'h00001;
endpackage

// >>> src/iocst_engine.sv
/*
 * Per-character transfer engine: search, translate, mask/test ops, CRC, count and
 * interrupt gating. Assumes the processor memory port answers each table read with
 * mem_rvalid_i some cycles later and takes one read at a time; all inputs are on clk_sys_i.
 */
// Behaviour
// R1: Order code zero passes characters unchanged, no search or translate.
// R2: Code 1 translates every character, no interrupt from fetched MSB.
// R3: Code 5 translates via translate base; fetched MSB one raises interrupt condition.
// R4: Code 6 searches via search base; fetched MSB one sets interrupt condition.
// R5: Code 7 searches then translates, both offset by the original character.
// R6: Packet mask byte maps bit-for-bit onto interrupt condition byte.
// R7: Interrupt raised only when mask AND condition byte is nonzero.
// R8: Condition byte and interrupt stay until read-and-reset clears them when pending.
// R9: Condition bits: hit, count zero, not ready, END_OF_RECORD, attention, error, carrier.
// R10: First address from packet word 1; bit 15 selects upper region.
// R11: Count holds negative length, increments per item, transfer ends at zero.
// R12: Search address is character plus search table base.
// R13: Search byte MSB set attempts a masked interrupt.
// R14: Translation applies to every character in both directions.
// R15: Translate reads base plus character and sends that byte instead.
// R16: Count overflow arrives on the flag line qualified by the window strobe.
// R17: Move bits 3,4 select source and destination halves; only bit 4 is used, choosing the output address half.
// R18: Move bit 5 zero increments addresses, one decrements both.
// R19: Move bit 6 selects normal move or diagnostic stack transfer.
// R20: Move bit 7 set suppresses all move interrupts.
// R21: Extended bit 1 places search base in upper memory.
// R22: Extended bit 3 computes CRC over moved data for packet word seven.
// R23: Extended bit 4 selects move with mask-and-test comparison.
// R24: Extended bits 5-7 select move, OR, AND or XOR with the test byte.
// R25: Unassigned order and operation codes behave like plain pass.
`timescale 1ns/10ps
module iocst_engine (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [7:0] order_byte_i,
    input wire logic [7:0] mask_byte_i,
    input wire logic [15:0] first_addr_i,
    input wire logic [15:0] count_i,
    input wire logic [15:0] xlate_base_i,
    input wire logic [15:0] search_base_i,
    input wire logic move_unit_i,
    input wire logic [7:0] ext_order_i,
    input wire logic [7:0] test_byte_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [7:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [7:0] out_data_o,
    output logic [16:0] out_addr_o,
    output logic mem_rd_o,
    output logic [16:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic io_flag_i,
    input wire logic flag_window_i,
    input wire logic [6:0] dev_events_i,
    input wire logic read_reset_i,
    output logic [7:0] icb_o,
    output logic irq_o,
    output logic busy_o,
    output logic [15:0] count_o,
    output logic [15:0] crc_o,
    output logic diag_o
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SRCH = 4'b0010,
        S_XLAT = 4'b0100,
        S_PUSH = 4'b1000
    } iocst_state_t;

    typedef struct packed {
        iocst_state_t st;
        logic [7:0] chr;
        logic [7:0] res;
        logic [16:0] addr;
        logic [15:0] cnt;
        logic [7:0] interrupt_condition_byte;
        logic irq;
        logic [15:0] crc;
        logic [1:0] vld;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [16:0] a0;
        logic [16:0] a1;
        logic wp;
        logic rp;
        logic [1:0] ev_s1;
        logic [1:0] ev_s2;
    } iocst_regs_t;

    iocst_regs_t r_q;
    iocst_regs_t r_d;

    // Decodes search use from the order code; unassigned codes do neither.
    function automatic logic f_search(input logic [2:0] c);
        return (c == iocst_pkg::COC_SEARCH) || (c == iocst_pkg::COC_BOTH);
    endfunction
    function automatic logic f_xlate(input logic [2:0] c);
        return (c == iocst_pkg::COC_XLATE) || (c == iocst_pkg::COC_XLATE_INT) || (c == iocst_pkg::COC_BOTH);
    endfunction
    // One CRC step over a byte, MSB first.
    function automatic logic [15:0] f_crc(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c;
        for (int i = 7; i >= 0; i--)
        begin
            v = (v[15] ^ d[i]) ? ((v << 1) ^ iocst_pkg::CRC_POLY) : (v << 1);
        end
        return v;
    endfunction

    logic [2:0] controller_order_code;
    logic [2:0] op;
    logic blocked_int;
    logic [7:0] ev_sync;
    assign controller_order_code = order_byte_i[7:5];
    assign op = ext_order_i[2:0];
    assign blocked_int = move_unit_i && order_byte_i[iocst_pkg::MV_NOINT]; // R20

    // Two-entry output buffer handshakes.
    // Only one character is ever in flight, so a slot must be free when it is taken;
    // accepting with both slots full would overwrite a word the receiver has not seen.
    assign in_ready_o = (r_q.st == S_IDLE) && busy_o && (r_q.vld < 2'h2) && (r_q.cnt != 16'h0000);
    assign out_valid_o = r_q.vld != 2'h0;
    assign out_data_o = r_q.rp ? r_q.b1 : r_q.b0;
    assign out_addr_o = r_q.rp ? r_q.a1 : r_q.a0;
    assign mem_rd_o = (r_q.st == S_SRCH) || (r_q.st == S_XLAT);
    assign icb_o = r_q.interrupt_condition_byte;
    assign irq_o = r_q.irq;
    assign count_o = r_q.cnt;
    assign crc_o = r_q.crc;
    assign busy_o = r_q.cnt != 16'h0000;
    assign diag_o = move_unit_i && order_byte_i[iocst_pkg::MV_DIAG]; // R19
    // Flag and window are synchronised separately and only combined after the second stage.
    assign ev_sync = {1'b0, r_q.ev_s2[0] & r_q.ev_s2[1], 6'h00}; // R16

    // Table address: base plus character; search base region chosen by extended bit.
    always_comb
    begin
        if (r_q.st == S_SRCH)
        begin
            mem_addr_o = {move_unit_i && ext_order_i[iocst_pkg::EX_STB_UPPER], search_base_i} // R21
                + {9'h000, r_q.chr}; // R12
        end
        else
        begin
            mem_addr_o = {1'b0, xlate_base_i} + {9'h000, r_q.chr}; // R15
        end
    end

    // Next-state logic for the whole engine.
    always_comb
    begin
        logic [7:0] newicb;
        logic push;
        logic pop;
        logic [7:0] val;
        newicb = 8'h00;
        push = 1'b0;
        pop = out_valid_o && out_ready_i;
        val = r_q.chr;
        r_d = r_q;
        r_d.ev_s1 = {flag_window_i, io_flag_i}; // R16
        r_d.ev_s2 = r_q.ev_s1;
        unique case (r_q.st)
            S_IDLE:
            begin
                if (in_valid_i && in_ready_o)
                begin
                    r_d.chr = in_data_i;
                    if (f_search(controller_order_code))
                        r_d.st = S_SRCH; // R4 R5
                    else if (f_xlate(controller_order_code))
                        r_d.st = S_XLAT; // R2 R3 R14
                    else
                        r_d.st = S_PUSH; // R1 R25
                end
            end
            S_SRCH:
            begin
                if (mem_rvalid_i)
                begin
                    if (mem_rdata_i[7])
                        newicb[iocst_pkg::ICB_SEARCH_HIT] = 1'b1; // R13
                    r_d.st = (controller_order_code == iocst_pkg::COC_BOTH) ? S_XLAT : S_PUSH; // R5
                end
            end
            S_XLAT:
            begin
                if (mem_rvalid_i)
                begin
                    if (controller_order_code == iocst_pkg::COC_XLATE_INT && mem_rdata_i[7])
                        newicb[iocst_pkg::ICB_SEARCH_HIT] = 1'b1; // R3
                    r_d.res = mem_rdata_i; // R15
                    r_d.st = S_PUSH;
                end
            end
            S_PUSH:
            begin
                push = 1'b1;
                r_d.st = S_IDLE;
            end
            default:
                r_d.st = S_IDLE;
        endcase
        if (r_q.st == S_PUSH)
        begin
            val = f_xlate(controller_order_code) ? r_q.res : r_q.chr; // R1 R14
            if (move_unit_i && ext_order_i[iocst_pkg::EX_MASKTEST]) // R23
            begin
                unique case (op)
                    iocst_pkg::OP_OR: val = val | test_byte_i; // R24
                    iocst_pkg::OP_AND: val = val & test_byte_i; // R24
                    iocst_pkg::OP_XOR: val = val ^ test_byte_i; // R24
                    default: val = val; // R25
                endcase
            end
        end
        // Buffer fill and drain; both may happen in one cycle.
        if (push)
        begin
            if (r_q.wp)
            begin
                r_d.b1 = val;
                r_d.a1 = r_q.addr;
            end
            else
            begin
                r_d.b0 = val;
                r_d.a0 = r_q.addr;
            end
            r_d.wp = ~r_q.wp;
            r_d.cnt = r_q.cnt + 16'h0001; // R11
            if (move_unit_i && order_byte_i[iocst_pkg::MV_STEP])
                r_d.addr = r_q.addr - iocst_pkg::ADDR_STEP; // R18
            else
                r_d.addr = r_q.addr + iocst_pkg::ADDR_STEP; // R18
            if (move_unit_i && ext_order_i[iocst_pkg::EX_CRC])
                r_d.crc = f_crc(r_q.crc, val); // R22
        end
        if (pop)
            r_d.rp = ~r_q.rp;
        r_d.vld = r_q.vld + {1'b0, push} - {1'b0, pop};
        // Count overflow reported by processor side, plus device events.
        newicb = newicb | ev_sync | {1'b0, dev_events_i}; // R16 R9
        if (push && r_q.cnt == 16'hFFFF)
            newicb[iocst_pkg::ICB_COUNT_ZERO] = 1'b1; // R11
        if (start_i && busy_o)
            newicb[iocst_pkg::ICB_NOT_READY] = 1'b1;
        if (blocked_int)
            newicb = 8'h00; // R20
        if (read_reset_i && r_q.irq)
            r_d.interrupt_condition_byte = newicb; // R8
        else
            r_d.interrupt_condition_byte = r_q.interrupt_condition_byte | newicb;
        r_d.irq = |(r_d.interrupt_condition_byte & mask_byte_i); // R6 R7
        if (start_i && !busy_o)
        begin
            // Address: bit 15 of word 1 selects upper region, mapped to bit 16.
            r_d.addr = {first_addr_i[iocst_pkg::ADDR_UPPER_BIT], 1'b0, first_addr_i[14:0]}; // R10
            if (move_unit_i)
                r_d.addr[16] = order_byte_i[iocst_pkg::MV_DIR_LO]; // R17
            r_d.cnt = count_i; // R11
            r_d.crc = iocst_pkg::CRC_INIT;
        end
        if (!rst_b_i)
        begin
            r_d = '0;
            r_d.st = S_IDLE;
        end
    end

    // Single state register; reset is folded in above.
    always_ff @(posedge clk_sys_i)
    begin
        r_q <= r_d;
    end

    // Transfer must stop at zero count: no new characters taken.
    count_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.cnt == 16'h0000) |-> !in_ready_o) else $error("character taken at zero count"); // R11
    // Interrupt reflects mask AND condition in the same cycle, unless the mask just changed.
    irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        irq_o == |(icb_o & mask_byte_i) || $changed(mask_byte_i)) else $error("irq not gated by mask"); // R7
    // Code zero leaves a word in the output buffer after its push.
    pass_plain_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_PUSH && controller_order_code == iocst_pkg::COC_NONE && !move_unit_i) |=> (r_q.vld != 2'h0)) else $error("pass lost"); // R1
    // Search code issues table read before push.
    search_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_IDLE && in_valid_i && in_ready_o && controller_order_code == iocst_pkg::COC_SEARCH) |=> mem_rd_o) else $error("no search read"); // R4
    // Code one never flags a hit from the table.
    xlate_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_XLAT && controller_order_code == iocst_pkg::COC_XLATE && mem_rvalid_i && !read_reset_i && dev_events_i == 7'h00
        && !r_q.interrupt_condition_byte[iocst_pkg::ICB_SEARCH_HIT]) |=> !r_q.interrupt_condition_byte[iocst_pkg::ICB_SEARCH_HIT]) else $error("code 1 hit"); // R2
    // Hit byte MSB sets the search bit.
    search_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_SRCH && mem_rvalid_i && mem_rdata_i[7] && !blocked_int) |=> r_q.interrupt_condition_byte[iocst_pkg::ICB_SEARCH_HIT]) else $error("hit lost"); // R13
    // Both-lookup code goes on to translate.
    both_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_SRCH && mem_rvalid_i && controller_order_code == iocst_pkg::COC_BOTH) |=> r_q.st == S_XLAT) else $error("no translate"); // R5
    // Condition byte holds without a read-and-reset.
    icb_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!read_reset_i && !start_i) |=> ((r_q.interrupt_condition_byte & $past(r_q.interrupt_condition_byte)) == $past(r_q.interrupt_condition_byte))) else $error("icb dropped"); // R8
    // The buffer never counts past two words.
    buf_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        r_q.vld != 2'h3) else $error("buffer overfilled"); // R15
    // A full buffer refuses the next character.
    ready_full_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.vld == 2'h2) |-> !in_ready_o) else $error("taken while full"); // R15
    // A waiting output word stays put until the receiver takes it.
    out_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o))) else $error("output word lost"); // R15
    // A table read holds until it is answered.
    read_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mem_rd_o && !mem_rvalid_i) |=> mem_rd_o) else $error("table read dropped"); // R12
    // The translated byte is what the table returned.
    xlate_take_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_XLAT && mem_rvalid_i) |=> (r_q.res == $past(mem_rdata_i))) else $error("table byte lost"); // R15
    // Search-only goes straight to the buffer after its lookup.
    search_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_SRCH && mem_rvalid_i && controller_order_code == iocst_pkg::COC_SEARCH) |=> r_q.st == S_PUSH) else $error("search only"); // R4
    // The last counted word raises the count-zero condition.
    count_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_PUSH && r_q.cnt == 16'hFFFF && !blocked_int)
        |=> r_q.interrupt_condition_byte[iocst_pkg::ICB_COUNT_ZERO]) else $error("count zero lost"); // R11
    // Inhibited moves raise no new condition bits.
    noint_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        blocked_int |=> ((r_q.interrupt_condition_byte & ~$past(r_q.interrupt_condition_byte)) == 8'h00)) else $error("inhibited interrupt set"); // R20
    // Decrement stepping walks the address down by one per word.
    step_down_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (r_q.st == S_PUSH && move_unit_i && order_byte_i[iocst_pkg::MV_STEP] && !start_i)
        |=> (r_q.addr == $past(r_q.addr) - iocst_pkg::ADDR_STEP)) else $error("step down wrong"); // R18
endmodule // iocst_engine

// >>> test/iocst_mem_model.sv
/*
 * Processor memory port model that answers each table read lat_i+1 cycles after it is raised.
 * Assumes one read at a time, held by the engine until it is answered.
 */
`timescale 1ns/10ps
module iocst_mem_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic mem_rd_i,
    input wire logic [16:0] mem_addr_i,
    input wire logic [3:0] lat_i,
    output logic mem_rvalid_o,
    output logic [7:0] mem_rdata_o
);
    logic [3:0] wait_q;

    // Idle data toggles every cycle so that a stale byte is never taken for a reply.
    always_ff @(posedge clk_sys_i)
    begin
        mem_rvalid_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!rst_b_i)
        begin
            wait_q <= 4'h0;
            mem_rdata_o <= 8'hA5;
        end
        else if (mem_rd_i && !mem_rvalid_o)
        begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == lat_i)
            begin
                wait_q <= 4'h0;
                mem_rvalid_o <= 1'b1;
                mem_rdata_o <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3C;
            end
        end
    end
endmodule // iocst_mem_model

// >>> test/io_channel_search_translate_bench.sv
/*
 * Self-checking bench for the search/translate engine with a memory port model.
 * Assumes a 250 MHz clock; inputs change 1 ns after each rising edge.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module io_channel_search_translate_bench;
    logic clk_sys_i, rst_b_i, start_i, move_unit_i, in_valid_i, in_ready_o, out_valid_o, out_ready_i, mem_rd_o;
    logic mem_rvalid_i, io_flag_i, flag_window_i, read_reset_i, irq_o, busy_o, diag_o, hit;
    logic [7:0] order_byte_i, mask_byte_i, ext_order_i, test_byte_i, in_data_i, out_data_o, mem_rdata_i, icb_o;
    logic [15:0] first_addr_i, count_i, xlate_base_i, search_base_i, count_o, crc_o, rnd_a, rnd_b;
    logic [16:0] out_addr_o, mem_addr_o;
    logic [6:0] dev_events_i;
    logic [3:0] lat;
    logic [7:0] exp_q[$];
    int failures, num_checks;

    // The engine's ports all carry the names of the bench signals.
    iocst_engine iocst_engine_inst (.*);
    iocst_mem_model iocst_mem_model_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mem_rd_i(mem_rd_o),
        .mem_addr_i(mem_addr_o), .lat_i(lat), .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

    function automatic logic [15:0] lf(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [7:0] tbl(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    function automatic logic [15:0] crcb(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] v;
        v = c;
        for (int i = 7; i >= 0; i--) v = (v[15] ^ d[i]) ? ((v << 1) ^ iocst_pkg::CRC_POLY) : (v << 1);
        return v;
    endfunction
    task automatic close_out();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tmo(input string s);
        failures++;
        $display("[FAIL] %s expected handshake seen timeout", s);
        close_out();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic reset_dut();
        rst_b_i = 1'b0;
        tick(8);
        rst_b_i = 1'b1;
        tick(1);
    endtask
    task automatic wbit(input int b);
        for (int j = 0; j < 10 && icb_o[b] !== 1'b1; j++) tick(1);
        `CHK("condition bit", 1'b1, icb_o[b]);
    endtask
    task automatic clr();
        logic p;
        p = irq_o;
        read_reset_i = 1'b1;
        tick(1);
        read_reset_i = 1'b0;
        tick(1);
        `CHK("hit after clear", hit & ~p, icb_o[7]);
        `CHK("irq after clear", 1'b0, irq_o);
    endtask

    // One packet: random bases and characters, a producer and a stalling receiver side by side.
    task automatic run(input logic [7:0] ob, input logic [7:0] eo, input logic mu, input logic [7:0] mk,
        input int n, input int stall);
        logic [7:0] c, t, s, d, e;
        logic [15:0] ea, cx;
        logic ok, ok2;
        int w, v;
        cx = iocst_pkg::CRC_INIT;
        order_byte_i = ob;
        ext_order_i = eo;
        move_unit_i = mu;
        mask_byte_i = mk;
        rnd_a = lf(rnd_a);
        first_addr_i = {rnd_a[15], 3'h4, rnd_a[11:0]};
        count_i = 16'h0000 - 16'(n);
        xlate_base_i = {rnd_a[7:0], rnd_a[15:8]};
        search_base_i = rnd_a ^ 16'h3A5C;
        test_byte_i = rnd_a[11:4];
        hit = 1'b0;
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
        fork
            begin
                in_valid_i = 1'b1;
                for (int i = 0; i < n; i++)
                begin
                    rnd_a = lf(rnd_a);
                    c = rnd_a[7:0];
                    in_data_i = c;
                    t = tbl(xlate_base_i + 16'(c));
                    s = tbl(search_base_i + 16'(c));
                    d = (ob[7:5] inside {3'h1, 3'h5, 3'h7}) ? t : c;
                    if (ob[7:5] == iocst_pkg::COC_XLATE_INT) hit = hit | t[7];
                    if (ob[7:5] >= iocst_pkg::COC_SEARCH) hit = hit | s[7];
                    if (mu && eo[3] && eo[2:0] == iocst_pkg::OP_OR) d = d | test_byte_i;
                    if (mu && eo[3] && eo[2:0] == iocst_pkg::OP_AND) d = d & test_byte_i;
                    if (mu && eo[3] && eo[2:0] == iocst_pkg::OP_XOR) d = d ^ test_byte_i;
                    if (mu && eo[4]) cx = crcb(cx, d);
                    exp_q.push_back(d);
                    for (w = 0; w < 300; w++)
                    begin
                        @(negedge clk_sys_i);
                        ok = in_ready_o;
                        tick(1);
                        if (ok === 1'b1) break;
                    end
                    if (w == 300) tmo("input accept");
                end
                in_valid_i = 1'b0;
            end
            begin
                if (stall > 0) tick(stall);
                for (int i = 0; i < n; i++)
                begin
                    for (v = 0; v < 300; v++)
                    begin
                        rnd_b = lf(rnd_b);
                        out_ready_i = rnd_b[0] | rnd_b[1];
                        @(negedge clk_sys_i);
                        ok2 = out_valid_o & out_ready_i;
                        if (ok2 === 1'b1)
                        begin
                            e = exp_q.pop_front();
                            ea = (mu && ob[2]) ? first_addr_i - 16'(i) : first_addr_i + 16'(i);
                            `CHK("out data", e, out_data_o);
                            `CHK("out addr", ea[14:0], out_addr_o[14:0]);
                            `CHK("addr region", mu ? ob[3] : first_addr_i[15], out_addr_o[16]);
                        end
                        tick(1);
                        if (ok2 === 1'b1) break;
                    end
                    if (v == 300) tmo("output");
                end
                out_ready_i = 1'b0;
            end
        join
        tick(2);
        `CHK("count", 16'h0000, count_o);
        `CHK("busy", 1'b0, busy_o);
        `CHK("ready at zero", 1'b0, in_ready_o);
        `CHK("search hit", hit, icb_o[7]);
        `CHK("irq", hit & mk[7], irq_o);
        `CHK("crc", cx, crc_o);
        `CHK("diag", mu & ob[1], diag_o);
    endtask

    // Free-running system clock.
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Main sequence: order codes, move unit, stalls, masking, flags and events.
    initial
    begin
        {start_i, move_unit_i, in_valid_i, out_ready_i, io_flag_i, flag_window_i, read_reset_i} = '0;
        {order_byte_i, mask_byte_i, ext_order_i, test_byte_i, in_data_i} = '0;
        {first_addr_i, count_i, xlate_base_i, search_base_i} = '0;
        dev_events_i = 7'h00;
        lat = 4'h0;
        rnd_a = 16'h7E86;
        rnd_b = 16'h7E86;
        failures = 0;
        num_checks = 0;
        hit = 1'b0;
        reset_dut();
        for (int k = 0; k < 8; k++)
        begin
            lat = 4'(k * 2);
            run({3'(k), 5'h00}, 8'h00, 1'b0, 8'h80, 6, 0);
            clr();
        end
        for (int k = 0; k < 8; k++)
        begin
            run({3'h0, 2'(k), k[2], k[0], 1'b0}, {3'h0, k[0], 1'b1, 3'(k)}, 1'b1, 8'h80, 4, 0);
            clr();
        end
        run(8'hE0, 8'h00, 1'b0, 8'h80, 10, 40);
        clr();
        run(8'hC0, 8'h00, 1'b0, 8'h00, 12, 0);
        clr();
        reset_dut();
        // The overflow flag only counts while the window strobe qualifies it.
        io_flag_i = 1'b1;
        tick(1);
        io_flag_i = 1'b0;
        tick(4);
        `CHK("flag outside window", 1'b0, icb_o[6]);
        io_flag_i = 1'b1;
        flag_window_i = 1'b1;
        tick(1);
        io_flag_i = 1'b0;
        flag_window_i = 1'b0;
        wbit(6);
        for (int b = 0; b < 6; b++)
        begin
            dev_events_i = 7'(1 << b);
            tick(1);
            dev_events_i = 7'h00;
            wbit(b);
        end
        reset_dut();
        // A second start during a transfer is reported as not ready.
        count_i = 16'hFFFE;
        start_i = 1'b1;
        tick(2);
        start_i = 1'b0;
        wbit(iocst_pkg::ICB_NOT_READY);
        close_out();
    end
endmodule // io_channel_search_translate_bench
